// File: bench/vlc_properties.sv
// Port-level checker bound to the compensator top
`timescale 1ns/100ps
module vlc_properties
    import vlc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic [1:0]  rail_index_i,
    input  wire logic        sync_out_o,
    input  wire logic        gate_o,
    input  wire logic        sat_o
);
    logic [15:0] sync_r;
    logic        ran_r;
    logic        wr;

    // Sync word shadow and enable history
    assign wr = psel_i && penable_i && pwrite_i && pready_o;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_r <= VLC_SYNC_RST;
            ran_r  <= 1'b0;
        end else begin
            if (wr && paddr_i == VLC_SYNC_ADDR) begin
                sync_r <= pwdata_i[15:0];
            end
            if (wr && paddr_i == VLC_CTRL_ADDR && pwdata_i[VLC_CTRL_EN_BIT]) begin
                ran_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // Access phase; sync driver naming another rail
    sequence s_access; psel_i && penable_i; endsequence
    sequence s_sync_off; (sync_r[15:8] != {6'h00, rail_index_i}) [*3]; endsequence

    property p_ready; pready_o; endproperty
    property p_err_phase; pslverr_o |-> psel_i && penable_i; endproperty
    property p_unmapped; s_access ##0 (paddr_i >= 12'h0A0) |-> pslverr_o; endproperty
    property p_mapped;
        s_access ##0 (paddr_i[1:0] == 2'b00 && (paddr_i <= VLC_STATUS_ADDR || paddr_i[11:5] inside {7'h02, 7'h03, 7'h04}))
        |-> !pslverr_o;
    endproperty
    property p_sync_read; s_access ##0 (!pwrite_i && paddr_i == VLC_SYNC_ADDR) |-> prdata_o[15:0] == sync_r; endproperty
    property p_sync_off; s_sync_off |-> !sync_out_o; endproperty
    property p_sync_pulse; sync_out_o |=> !sync_out_o; endproperty
    property p_reset_out; $fell(reset_i) |-> !gate_o && !sync_out_o && !sat_o; endproperty
    property p_gate_idle; !ran_r |-> !gate_o; endproperty

    a_ready: assert property (p_ready)
        else $error("pready low");
    a_err_phase: assert property (p_err_phase)
        else $error("pslverr outside access phase");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    a_mapped: assert property (p_mapped)
        else $error("mapped access refused");
    a_sync_read: assert property (p_sync_read)
        else $error("sync word read back differs");
    a_sync_off: assert property (p_sync_off)
        else $error("sync output from unselected rail");
    a_sync_pulse: assert property (p_sync_pulse)
        else $error("sync pulse over one cycle");
    a_reset_out: assert property (p_reset_out)
        else $error("outputs active after reset");
    a_gate_idle: assert property (p_gate_idle)
        else $error("gate driven before enable");
endmodule : vlc_properties

bind vlc_top vlc_properties u_vlc_properties (.*);

// File: bench/vlc_stage.sv
// Behavioural output sense network
`timescale 1ns/100ps
module vlc_stage (
    input  wire logic [11:0] level_i,
    output logic      [11:0] sense_positive_input_o,
    output logic      [11:0] sense_negative_input_o
);
    // Common-mode offset; only the difference counts
    localparam logic [11:0] COMMON = 12'h064;

    // Divided output level in mV across the pair
    assign sense_positive_input_o = level_i + COMMON;
    assign sense_negative_input_o = COMMON;
endmodule : vlc_stage

// File: bench/vlc_top_tb.sv
// Self-checking bench for the voltage loop compensator
`timescale 1ns/100ps
module vlc_top_tb;
    import vlc_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        sync_in = 1'b0, nbr = 1'b0, er, pready, pslverr, sync_out, gate, sat;
    logic [11:0] paddr = 12'h000, level = 12'h000, sp, sn;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
    int          mismatches = 0, checked = 0, n, hi;
    logic [11:0] ra[4] = '{VLC_PERIOD_ADDR, VLC_SYNC_ADDR, VLC_LIMIT_ADDR, VLC_TRIG_ADDR};
    logic [31:0] rv[4] = '{32'(VLC_PERIOD_RST), 32'(VLC_SYNC_RST), VLC_LIMIT_RST, 32'(VLC_TRIG_RST)};
    int          bk[5] = '{0, 1, 2, 1, 0}, ex[5] = '{3, 6, 12, 24, 3}, ct[5] = '{3, 1, 5, 1, 7};

    vlc_top #(.SLEW_CYCLES(4)) u_vlc_top (.mclk_i(mclk), .reset_i(reset), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sense_positive_input_i(sp), .sense_negative_input_i(sn), .sync_in_i(sync_in),
        .neighbour_start_i(nbr), .rail_index_i(2'b00), .sync_out_o(sync_out), .gate_o(gate), .sat_o(sat));
    vlc_stage u_vlc_stage (.level_i(level), .sense_positive_input_o(sp), .sense_negative_input_o(sn));

    // Free-running 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : cyc

    task automatic do_reset;
        reset <= 1'b1;
        cyc(3);
        reset <= 1'b0;
    endtask : do_reset

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (k == 64) mismatches++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Cycles between sync pulses; kind 1 raises sync in, 2 pulses neighbour
    task automatic gap(input int kind);
        int k;
        k = 0;
        while (sync_out !== 1'b1 && k < 200) begin
            @(posedge mclk);
            k++;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            sync_in <= (kind == 1 && n >= 20);
            nbr <= (kind == 2 && n == 20);
        end while (sync_out !== 1'b1 && n < 200);
        sync_in <= 1'b0;
    endtask : gap

    // Saturate after reset, watch reference slew
    task automatic sat_run(input logic [9:0] cmd, input logic [11:0] lvl, input logic [6:0] e, input logic up);
        logic [9:0] v1, d;
        do_reset();
        level <= lvl;
        apb(1'b1, VLC_PERIOD_ADDR, 32'h0000_0032);
        apb(1'b1, 12'(VLC_BANK_BASE_ADDR + VLC_BANK_STRIDE), 32'h0000_0003);
        apb(1'b1, VLC_VREF_ADDR, 32'(cmd));
        apb(1'b1, VLC_CTRL_ADDR, 32'h0000_0001);
        cyc(200);
        apb(1'b0, VLC_STATUS_ADDR, 32'h0000_0000);
        chk("clamped code", {24'h0, 1'b1, e}, {24'h0, rd[8], rd[6:0]});
        chk("sat flag", 32'h0000_0001, {31'h0, sat});
        apb(1'b0, VLC_VREF_ADDR, 32'h0000_0000);
        v1 = rd[25:16];
        cyc(400);
        apb(1'b0, VLC_VREF_ADDR, 32'h0000_0000);
        d = up ? rd[25:16] - v1 : v1 - rd[25:16];
        chk("reference slew", 32'h0000_0001, {31'h0, d >= 10'd98 && d <= 10'd103});
    endtask : sat_run

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Run is a few thousand cycles
    initial begin
        cyc(20000);
        mismatches++;
        print_verdict();
    end

    initial begin
        do_reset();
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0000_0000);
            chk("reset value", rv[i], rd);
        end
        apb(1'b1, 12'h0A0, 32'hFFFF_FFFF);
        chk("unmapped write error", 32'h0000_0001, {31'h0, er});
        apb(1'b0, 12'h01C, 32'h0000_0000);
        chk("unmapped read error", 32'h0000_0001, {31'h0, er});
        $display("test done: reset and map");
        // +24 mV error through each bank and gain
        level <= 12'h190;
        apb(1'b1, VLC_PERIOD_ADDR, 32'h0000_0032);
        apb(1'b1, VLC_TRIG_ADDR, 32'h0000_000A);
        apb(1'b1, VLC_LIMIT_ADDR, 32'h0201_FEFC);
        apb(1'b1, VLC_VREF_ADDR, 32'h0000_01A8);
        apb(1'b1, 12'(VLC_BANK_BASE_ADDR + 4 * VLC_BW_B0), 32'h0000_2000);
        apb(1'b1, 12'(VLC_BANK_BASE_ADDR + 4 * VLC_BW_FO), 32'h4000_0000);
        foreach (bk[i]) begin
            apb(1'b1, 12'(VLC_BANK_BASE_ADDR + VLC_BANK_STRIDE * bk[i]), 32'(i % 4));
            apb(1'b1, VLC_CTRL_ADDR, 32'(ct[i]));
            cyc(150);
            apb(1'b0, VLC_STATUS_ADDR, 32'h0000_0000);
            chk("error code", 32'(ex[i]), {23'h0, rd[8:0]});
        end
        $display("test done: gain and banks");
        // A whole period holds threshold cycles of gate
        apb(1'b0, VLC_STATUS_ADDR, 32'h0000_0000);
        hi = 0;
        repeat (50) begin
            @(posedge mclk);
            hi += (gate === 1'b1);
        end
        chk("gate width", (32'(rd[31:16]) * 32'h0000_0032) >> 14, 32'(hi));
        $display("test done: pulse width");
        apb(1'b1, VLC_SYNC_ADDR, 32'h0000_0000);
        gap(0);
        chk("sync period", 32'h0000_0032, 32'(n));
        gap(1);
        chk("sync ignored", 32'h0000_0032, 32'(n));
        apb(1'b1, VLC_CTRL_ADDR, 32'h0000_000F);
        gap(2);
        chk("neighbour realign", 32'h0000_0001, {31'h0, n < 30});
        apb(1'b1, VLC_SYNC_ADDR, 32'h0000_0001);
        gap(1);
        chk("sync realign", 32'h0000_0001, {31'h0, n < 30});
        apb(1'b1, VLC_SYNC_ADDR, 32'h0000_0100);
        gap(0);
        chk("sync disabled", 32'h0000_00C8, 32'(n));
        $display("test done: synchronisation");
        sat_run(10'h3E8, 12'h000, 7'h1F, 1'b0);
        sat_run(10'h000, 12'h3E8, 7'h60, 1'b1);
        $display("test done: saturation");
        print_verdict();
    end
endmodule : vlc_top_tb

// File: rtl/vlc_nonlinear.sv
// Nonlinear region gain stage for the loop error
`timescale 1ns/100ps
module vlc_nonlinear
    import vlc_pkg::*;
(
    input  wire logic signed [6:0]  err_i,
    input  wire logic        [31:0] limits_i,
    input  wire logic        [15:0] gains_i,
    output logic signed      [21:0] out_o
);
    logic signed [7:0] lim [4];
    logic        [1:0] region;
    logic        [3:0] shift;

    // Limits are taken as signed bytes, so any asymmetric set is honoured
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lim
            assign lim[g] = limits_i[8*g +: 8];
        end
    endgenerate

    // Region counts lower limits exceeded, 2 above lim[2], 3 above lim[3]; all-positive limits leave negatives in region 0
    always_comb begin
        region = 2'd0;
        if (8'(err_i) > lim[2]) begin
            region = (8'(err_i) > lim[3]) ? 2'd3 : 2'd2;  // RQ10
        end else if (8'(err_i) > lim[0]) begin
            region = (8'(err_i) > lim[1]) ? 2'd2 : 2'd1;  // RQ10
        end
        shift = gains_i[4*region +: 4];
        out_o = 22'(22'(err_i) <<< shift);  // RQ7
    end
endmodule : vlc_nonlinear

// File: rtl/vlc_pkg.sv
// Package of constants, register map and types for the voltage loop compensator
// Function
// [RQ1] Sense capture instant set by trigger register
// [RQ2] Error equals ten-bit reference minus sensed value
// [RQ3] Gain code 0..3 selects gain 1,2,4,8
// [RQ4] Each coefficient bank holds its own gain code
// [RQ5] Converter clamps error to -32 or 31 LSBs
// [RQ6] Saturation slews reference toward sense at 0.156V/ms
// [RQ7] Nonlinear gain, then second-order, then first-order filter
// [RQ8] First-order section adds third zero and pole
// [RQ9] Bank zero ramping, one regulation, two light load
// [RQ10] Four signed limits pick region gain, asymmetric allowed
// [RQ11] Software keeps lower limits negative, upper positive
// [RQ12] Duty times period gives comparator threshold
// [RQ13] Threshold compared with period counter forms pulse
// [RQ14] Period aligns to neighbour or sync input; sync out
// [RQ15] Gate high from period start while counter below threshold
// [RQ16] Rising sync input resets following rail counters
// [RQ17] Sync word: upper byte driver rail, lower byte followers
package vlc_pkg;
    // Register byte addresses
    localparam logic [11:0] VLC_CTRL_ADDR      = 12'h000;
    localparam logic [11:0] VLC_PERIOD_ADDR    = 12'h004;
    localparam logic [11:0] VLC_TRIG_ADDR      = 12'h008;
    localparam logic [11:0] VLC_VREF_ADDR      = 12'h00C;
    localparam logic [11:0] VLC_SYNC_ADDR      = 12'h010;
    localparam logic [11:0] VLC_LIMIT_ADDR     = 12'h014;
    localparam logic [11:0] VLC_STATUS_ADDR    = 12'h018;
    localparam logic [11:0] VLC_BANK_BASE_ADDR = 12'h040;
    // Per-bank block: 8 words from base + 32*bank
    localparam int          VLC_BANK_STRIDE    = 32;
    // Bank word indices
    localparam int          VLC_BW_GAIN        = 0;  // [1:0] gain code
    localparam int          VLC_BW_NLG         = 1;  // Four 4-bit nonlinear gains (shift)
    localparam int          VLC_BW_B0          = 2;
    localparam int          VLC_BW_B1          = 3;
    localparam int          VLC_BW_B2          = 4;
    localparam int          VLC_BW_A1          = 5;
    localparam int          VLC_BW_A2          = 6;
    localparam int          VLC_BW_FO          = 7;  // [31:16] c0, [15:0] pole d1
    // Control bit fields
    localparam int          VLC_CTRL_EN_BIT    = 0;
    localparam int          VLC_CTRL_RAMP_BIT  = 1;
    localparam int          VLC_CTRL_LIGHT_BIT = 2;
    localparam int          VLC_CTRL_ALIGN_BIT = 3;
    // Reset values
    localparam logic [15:0] VLC_PERIOD_RST     = 16'h01F4;
    localparam logic [15:0] VLC_TRIG_RST       = 16'h0000;
    localparam logic [9:0]  VLC_VREF_RST       = 10'h000;
    localparam logic [15:0] VLC_SYNC_RST       = 16'hFF00;
    localparam logic [31:0] VLC_LIMIT_RST      = 32'h0201_FEFC;
    // Error converter limits in LSBs
    localparam int          VLC_ERR_MIN        = -32;
    localparam int          VLC_ERR_MAX        = 31;
    // Reference slew: 0.156 V/ms at the sense inputs, 1 mV per DAC step
    localparam real         VLC_SLEW_V_PER_MS  = 0.156;
    localparam real         VLC_VREF_LSB_MV    = 1.0;
    localparam real         VLC_CLK_MHZ        = 100.0;
    localparam int          VLC_SLEW_CYCLES    =
        int'($floor(VLC_CLK_MHZ * 1000.0 * VLC_VREF_LSB_MV / (VLC_SLEW_V_PER_MS * 1000.0)));
    localparam int          VLC_FRAC           = 14; // Coefficient fraction bits
    typedef enum logic [1:0] {VLC_BANK_RAMP, VLC_BANK_REG, VLC_BANK_LIGHT} vlc_bank_t;
endpackage : vlc_pkg

// File: rtl/vlc_pulse.sv
// Pulse engine: period counter, threshold compare and sync handling
`timescale 1ns/100ps
module vlc_pulse
    import vlc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        enable_i,
    input  wire logic [15:0] period_i,
    input  wire logic [15:0] thresh_i,
    input  wire logic        sync_rise_i,
    input  wire logic        follow_i,
    input  wire logic        align_i,
    output logic      [15:0] count_o,
    output logic             start_o,
    output logic             gate_o
);
    logic [15:0] count_r;
    logic        gate_r;

    // Period counter; sync or neighbour start restarts it
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            count_r <= 16'h0000;
        end else if (!enable_i) begin
            count_r <= 16'h0000;
        end else if ((sync_rise_i && follow_i) || align_i) begin
            count_r <= 16'h0000;  // RQ16 RQ14
        end else if (count_r >= period_i - 16'h0001) begin
            count_r <= 16'h0000;
        end else begin
            count_r <= count_r + 16'h0001;  // RQ13
        end
    end

    // Gate high from period start while counter is under threshold
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= enable_i && (count_r < thresh_i);  // RQ15 RQ13
        end
    end

    assign count_o = count_r;
    assign start_o = enable_i && (count_r == 16'h0000);
    assign gate_o  = gate_r;
endmodule : vlc_pulse

// File: rtl/vlc_top.sv
// Voltage loop compensator top: APB registers, error path, filter and pulse engine
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
module vlc_top
    import vlc_pkg::*;
#(
    parameter int SLEW_CYCLES = VLC_SLEW_CYCLES
)(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [11:0] sense_positive_input_i,
    input  wire logic [11:0] sense_negative_input_i,
    input  wire logic        sync_in_i,
    input  wire logic        neighbour_start_i,
    input  wire logic [1:0]  rail_index_i,
    output logic             sync_out_o,
    output logic             gate_o,
    output logic             sat_o
);
    // Registers
    logic        ctrl_en_r, ctrl_ramp_r, ctrl_light_r, ctrl_align_r;
    logic [15:0] period_r;
    logic [15:0] error_sample_instant_r;
    logic [9:0]  vref_cmd_r;
    logic [15:0] sync_word_r;
    logic [31:0] limits_r;
    logic [31:0] bank_r [3][8];
    logic [31:0] prdata_r;
    logic        pslverr_r;

    // Datapath state
    logic [9:0]          vref_r;
    logic signed [6:0]   err_r;
    logic                sat_r;
    logic                sample_r, filt_go_r;
    logic [31:0]         slew_cnt_r;
    logic signed [23:0]  x1_r, x2_r, y1_r, y2_r, z1_r, w1_r;
    logic [15:0]         duty_r;
    logic [15:0]         thresh_r;
    logic [2:0]          sync_ff_r;
    logic                sync_out_r;

    // Combinational
    logic                acc_wr, acc_rd;
    logic [1:0]          bank_sel;
    logic [1:0]          gain_code;
    logic signed [13:0]  diff;
    logic signed [13:0]  scaled;
    logic signed [21:0]  nl_out;
    logic signed [23:0]  x0, y0, w0;
    logic [15:0]         count;
    logic                pstart, sync_rise;

    // Bank index of an address in the coefficient area, 3 when outside
    function automatic logic [1:0] bank_of(input logic [11:0] a);
        if (a >= VLC_BANK_BASE_ADDR && a < VLC_BANK_BASE_ADDR + 12'(3 * VLC_BANK_STRIDE)) begin
            return 2'((a - VLC_BANK_BASE_ADDR) >> 5);
        end
        return 2'd3;
    endfunction : bank_of

    // Signed 16-bit coefficient times 24-bit state, rescaled
    function automatic logic signed [23:0] cmul(input logic [15:0] c, input logic signed [23:0] v);
        logic signed [39:0] p;
        p = $signed(c) * v;
        return 24'(p >>> VLC_FRAC);
    endfunction : cmul

    assign acc_wr    = psel_i && penable_i && pwrite_i;
    assign acc_rd    = psel_i && !pwrite_i;
    assign pready_o  = 1'b1;  // Zero wait states
    assign prdata_o  = prdata_r;
    assign pslverr_o = pslverr_r & psel_i & penable_i;

    // Control, period, trigger, reference, sync and limit registers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_en_r              <= 1'b0;
            ctrl_ramp_r            <= 1'b1;
            ctrl_light_r           <= 1'b0;
            ctrl_align_r           <= 1'b0;
            period_r               <= VLC_PERIOD_RST;
            error_sample_instant_r <= VLC_TRIG_RST;
            vref_cmd_r             <= VLC_VREF_RST;
            sync_word_r            <= VLC_SYNC_RST;
            limits_r               <= VLC_LIMIT_RST;
        end else if (acc_wr) begin
            if (paddr_i == VLC_CTRL_ADDR) begin
                ctrl_en_r    <= pwdata_i[VLC_CTRL_EN_BIT];
                ctrl_ramp_r  <= pwdata_i[VLC_CTRL_RAMP_BIT];
                ctrl_light_r <= pwdata_i[VLC_CTRL_LIGHT_BIT];
                ctrl_align_r <= pwdata_i[VLC_CTRL_ALIGN_BIT];
            end else if (paddr_i == VLC_PERIOD_ADDR) begin
                period_r <= pwdata_i[15:0];
            end else if (paddr_i == VLC_TRIG_ADDR) begin
                error_sample_instant_r <= pwdata_i[15:0];  // RQ1
            end else if (paddr_i == VLC_VREF_ADDR) begin
                vref_cmd_r <= pwdata_i[9:0];
            end else if (paddr_i == VLC_SYNC_ADDR) begin
                sync_word_r <= pwdata_i[15:0];  // RQ17
            end else if (paddr_i == VLC_LIMIT_ADDR) begin
                limits_r <= pwdata_i;  // RQ10
            end
        end
    end

    // Coefficient banks, each with its own gain code
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int b = 0; b < 3; b++) begin
                for (int w = 0; w < 8; w++) begin
                    bank_r[b][w] <= 32'h0000_0000;
                end
            end
        end else if (acc_wr && bank_of(paddr_i) != 2'd3) begin
            bank_r[bank_of(paddr_i)][paddr_i[4:2]] <= pwdata_i;  // RQ4
        end
    end

    // Read mux and error answer for unmapped addresses
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            if (bank_of(paddr_i) != 2'd3) begin
                if (acc_rd) prdata_r <= bank_r[bank_of(paddr_i)][paddr_i[4:2]];
            end else if (paddr_i == VLC_CTRL_ADDR) begin
                if (acc_rd) prdata_r <= {28'h000_0000, ctrl_align_r, ctrl_light_r, ctrl_ramp_r, ctrl_en_r};
            end else if (paddr_i == VLC_PERIOD_ADDR) begin
                if (acc_rd) prdata_r <= {16'h0000, period_r};
            end else if (paddr_i == VLC_TRIG_ADDR) begin
                if (acc_rd) prdata_r <= {16'h0000, error_sample_instant_r};
            end else if (paddr_i == VLC_VREF_ADDR) begin
                if (acc_rd) prdata_r <= {6'h00, vref_r, 6'h00, vref_cmd_r};
            end else if (paddr_i == VLC_SYNC_ADDR) begin
                if (acc_rd) prdata_r <= {16'h0000, sync_word_r};
            end else if (paddr_i == VLC_LIMIT_ADDR) begin
                if (acc_rd) prdata_r <= limits_r;
            end else if (paddr_i == VLC_STATUS_ADDR) begin
                if (acc_rd) prdata_r <= {duty_r, 7'h00, sat_r, 1'b0, err_r};
            end else begin
                pslverr_r <= 1'b1;
            end
        end
    end

    // Bank choice: ramp mode first, then light load, else regulation
    always_comb begin
        if (ctrl_ramp_r) begin
            bank_sel = VLC_BANK_RAMP;  // RQ9
        end else if (ctrl_light_r) begin
            bank_sel = VLC_BANK_LIGHT;  // RQ9
        end else begin
            bank_sel = VLC_BANK_REG;  // RQ9
        end
        gain_code = bank_r[bank_sel][VLC_BW_GAIN][1:0];  // RQ4
    end

    // Error in mV scaled by 1,2,4,8 so one LSB is 8,4,2,1 mV
    always_comb begin
        diff   = $signed({4'h0, vref_r}) - ($signed({2'b00, sense_positive_input_i})
                 - $signed({2'b00, sense_negative_input_i}));  // RQ2
        scaled = 14'(diff <<< gain_code) >>> 3;  // RQ3
    end

    // Capture at the programmed instant; clamp on converter range
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            err_r    <= 7'sd0;
            sat_r    <= 1'b0;
            sample_r <= 1'b0;
        end else begin
            sample_r <= ctrl_en_r && (count == error_sample_instant_r);  // RQ1
            if (sample_r) begin
                if (scaled < 14'(VLC_ERR_MIN)) begin
                    err_r <= 7'(VLC_ERR_MIN);  // RQ5
                    sat_r <= 1'b1;
                end else if (scaled > 14'(VLC_ERR_MAX)) begin
                    err_r <= 7'(VLC_ERR_MAX);  // RQ5
                    sat_r <= 1'b1;
                end else begin
                    err_r <= 7'(scaled);
                    sat_r <= 1'b0;
                end
            end
        end
    end

    // Reference follows command, or slews 1 mV per step while saturated
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            vref_r     <= VLC_VREF_RST;
            slew_cnt_r <= 32'h0000_0000;
        end else if (!sat_r) begin
            vref_r     <= vref_cmd_r;
            slew_cnt_r <= 32'h0000_0000;
        end else if (slew_cnt_r >= 32'(SLEW_CYCLES - 1)) begin
            slew_cnt_r <= 32'h0000_0000;
            // Positive error means reference above sense: step down
            if (err_r > 0 && vref_r != 10'h000) vref_r <= vref_r - 10'h001;  // RQ6
            else if (err_r < 0 && vref_r != 10'h3FF) vref_r <= vref_r + 10'h001;  // RQ6
        end else begin
            slew_cnt_r <= slew_cnt_r + 32'h0000_0001;
        end
    end

    vlc_nonlinear u_nl (
        .err_i    (err_r),
        .limits_i (limits_r),
        .gains_i  (bank_r[bank_sel][VLC_BW_NLG][15:0]),
        .out_o    (nl_out)
    );

    // Second-order section then first-order section in cascade
    always_comb begin
        x0 = 24'(nl_out);
        y0 = cmul(bank_r[bank_sel][VLC_BW_B0][15:0], x0) + cmul(bank_r[bank_sel][VLC_BW_B1][15:0], x1_r)
           + cmul(bank_r[bank_sel][VLC_BW_B2][15:0], x2_r) + cmul(bank_r[bank_sel][VLC_BW_A1][15:0], y1_r)
           + cmul(bank_r[bank_sel][VLC_BW_A2][15:0], y2_r);  // RQ7
        w0 = cmul(bank_r[bank_sel][VLC_BW_FO][31:16], y0)
           + cmul(bank_r[bank_sel][VLC_BW_FO][15:0], w1_r) + z1_r;  // RQ8
    end

    // Filter update once per sample; duty clamped to 0..100 percent
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            filt_go_r <= 1'b0;
            x1_r <= 24'sd0;
            x2_r <= 24'sd0;
            y1_r <= 24'sd0;
            y2_r <= 24'sd0;
            z1_r <= 24'sd0;
            w1_r <= 24'sd0;
            duty_r <= 16'h0000;
        end else begin
            filt_go_r <= sample_r;
            if (filt_go_r) begin
                x2_r <= x1_r;
                x1_r <= x0;
                y2_r <= y1_r;
                y1_r <= y0;
                z1_r <= -cmul(bank_r[bank_sel][VLC_BW_FO][31:16], y1_r) + 24'(0);
                w1_r <= w0;
                if (w0 < 0) duty_r <= 16'h0000;
                else if (w0 > 24'sh00_4000) duty_r <= 16'h4000;  // 1.0 in Q14
                else duty_r <= 16'(w0);
            end
        end
    end

    // Threshold = duty (Q14) times period
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            thresh_r <= 16'h0000;
        end else if (pstart) begin
            thresh_r <= 16'((32'(duty_r) * 32'(period_r)) >> VLC_FRAC);  // RQ12
        end
    end

    // Sync input: two flip-flops, then edge detect on the synchronised copies
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_ff_r <= 3'b000;
        end else begin
            sync_ff_r <= {sync_ff_r[1:0], sync_in_i};
        end
    end
    assign sync_rise = sync_ff_r[1] && !sync_ff_r[2];

    // Sync out pulses at the period start when this rail is selected
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_out_r <= 1'b0;
        end else begin
            sync_out_r <= pstart && (sync_word_r[15:8] == {6'h00, rail_index_i});  // RQ14 RQ17
        end
    end

    vlc_pulse u_pulse (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .enable_i    (ctrl_en_r),
        .period_i    (period_r),
        .thresh_i    (thresh_r),
        .sync_rise_i (sync_rise),
        .follow_i    (sync_word_r[rail_index_i]),  // RQ16 RQ17
        .align_i     (ctrl_align_r && neighbour_start_i),  // RQ14
        .count_o     (count),
        .start_o     (pstart),
        .gate_o      (gate_o)
    );

    assign sync_out_o = sync_out_r;
    assign sat_o      = sat_r;
endmodule : vlc_top
